// ===== logic/usi_bus_condition.sv
`timescale 1ns/1ps
module usi_bus_condition (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // synchronised line state
   input wire logic i_enable,
   input wire logic i_scl,
   input wire logic i_sda_rise,
   input wire logic i_sda_fall,
   // detected conditions, one-cycle pulses
   output logic o_start,
   output logic o_stop
);
   logic start;
   logic stop;
   logic next_start;
   logic next_stop;

   // data moving while clock high marks a bus condition
   always_comb begin
      next_start = i_enable & i_scl & i_sda_fall;
      next_stop = i_enable & i_scl & i_sda_rise;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         start <= 1'b0;
         stop <= 1'b0;
      end else begin
         start <= next_start;
         stop <= next_stop;
      end
   end

   assign o_start = start;
   assign o_stop = stop;
endmodule : usi_bus_condition

// ===== logic/usi_core.sv
// What this block does
// RULE1: external clock counts on both pin edges
// RULE2: overflow pulse chains counter into companion timer
// RULE3: preset counter overflows on one external edge
// RULE4: data writes win over a coincident shift
// RULE5: shift left per selected clock source
// RULE6: data pin driven from latched msb
// RULE7: latch open first half, or always internally
// RULE8: open latch passes newly written msb
// RULE9: inputs still clock with wires disabled
// RULE10: start flag on start or clock edges
// RULE11: start flag interrupts, wakes, cleared by one
// RULE12: overflow flag on wrap, wakes idle only
// RULE13: overflow cleared by one or buffer read
// RULE14: stop flag on stop, no interrupt
// RULE15: collision when msb differs from data pin
// RULE16: counter readable and writable in status
// RULE17: counter clocked by selected source
// RULE18: toggle strobe clocks counter when selected
// RULE19: control register layout, reset zero
// RULE20: status register layout, reset zero
// RULE21: pending flag interrupts once enables set
// RULE22: wire mode selects outputs and holds
// RULE23: soft strobe clocks shift and counter
// RULE24: counter write wins over increment
`timescale 1ns/1ps
module usi_core
   import usi_pkg::*;
(
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   // i/o register port
   input wire logic [5:0] I_IO_ADDR,
   input wire logic [7:0] I_IO_WDATA,
   input wire logic I_IO_WE,
   input wire logic I_IO_RE,
   output logic [7:0] O_IO_RDATA,
   // processor side
   input wire logic I_GLOBAL_INT_EN,
   input wire logic I_TIMER_MATCH,
   output logic O_START_IRQ,
   output logic O_OVF_IRQ,
   output logic O_WAKE_ANY,
   output logic O_WAKE_IDLE,
   output logic O_COUNTER_OVF,
   output logic O_CLOCK_TOGGLE,
   // serial pins
   input wire logic I_SERIAL_IN_PIN,
   input wire logic I_SERIAL_CLOCK_PIN,
   output logic O_DATA_OUT,
   output logic O_DATA_OUT_EN,
   output logic O_SDA_OUT,
   output logic O_SDA_OE_N,
   output logic O_SCL_OUT,
   output logic O_SCL_OE_N
);
   import usi_pkg::*;

   logic [1:0] pin_level;
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;
   logic sda_level;
   logic scl_level;
   logic scl_edge;
   logic start_det;
   logic stop_det;

   // control state
   logic start_int_enable;
   logic ovf_int_enable;
   logic [1:0] wire_select;
   logic [1:0] clock_source_select;
   logic ext_soft_sel;
   logic next_start_int_enable;
   logic next_ovf_int_enable;
   logic [1:0] next_wire_select;
   logic [1:0] next_clock_source_select;
   logic next_ext_soft_sel;

   // data path state
   logic start_cond_flag;
   logic counter_ovf_flag;
   logic stop_cond_flag;
   logic [3:0] counter_value;
   logic [7:0] shift_data_register;
   logic [7:0] receive_buffer_register;
   logic out_latch;
   logic ovf_pulse;
   logic toggle_pulse;
   logic [7:0] rdata;
   hold_state_t hold_state;
   logic next_start_cond_flag;
   logic next_counter_ovf_flag;
   logic next_stop_cond_flag;
   logic [3:0] next_counter_value;
   logic [7:0] next_shift_data_register;
   logic [7:0] next_receive_buffer_register;
   logic next_out_latch;
   logic next_ovf_pulse;
   logic next_toggle_pulse;
   logic [7:0] next_rdata;
   hold_state_t next_hold_state;

   // decoded strobes
   logic ctl_wr;
   logic st_wr;
   logic dat_wr;
   logic buf_rd;
   logic soft_stb;
   logic tog_stb;
   logic [1:0] eff_cs;
   logic eff_soft_sel;
   logic shift_clk;
   logic cnt_clk;
   logic ovf_evt;
   logic two_wire;
   logic transparent;
   logic collision;
   logic scl_hold;

   function automatic logic hit(input logic [5:0] addr, input logic [5:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction : hit

   // index 0 is data line, index 1 is clock line
   usi_pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_pins({I_SERIAL_CLOCK_PIN, I_SERIAL_IN_PIN}),
      .o_level(pin_level),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   assign sda_level = pin_level[0];
   assign scl_level = pin_level[1];
   assign scl_edge = pin_rise[1] | pin_fall[1]; // RULE1
   assign two_wire = wire_select[1];

   usi_bus_condition u_cond (
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_enable(two_wire), // RULE22
      .i_scl(scl_level),
      .i_sda_rise(pin_rise[0]),
      .i_sda_fall(pin_fall[0]),
      .o_start(start_det),
      .o_stop(stop_det)
   );

   // register writes and clock source selection
   always_comb begin
      ctl_wr = I_IO_WE & hit(I_IO_ADDR, ADDR_CONTROL);
      st_wr = I_IO_WE & hit(I_IO_ADDR, ADDR_STATUS);
      dat_wr = I_IO_WE & hit(I_IO_ADDR, ADDR_DATA);
      buf_rd = I_IO_RE & hit(I_IO_ADDR, ADDR_BUFFER);
      soft_stb = ctl_wr & I_IO_WDATA[CTL_SOFT_CLK];
      tog_stb = ctl_wr & I_IO_WDATA[CTL_TOGGLE];
      // a control write takes effect together with its own strobes
      eff_cs = ctl_wr ? I_IO_WDATA[CTL_CS_HI:CTL_CS_LO] : clock_source_select;
      eff_soft_sel = ctl_wr ? (I_IO_WDATA[CTL_CS_HI] & I_IO_WDATA[CTL_SOFT_CLK]) : ext_soft_sel;
      next_start_int_enable = start_int_enable;
      next_ovf_int_enable = ovf_int_enable;
      next_wire_select = wire_select;
      next_clock_source_select = clock_source_select;
      next_ext_soft_sel = ext_soft_sel;
      if (ctl_wr) begin
         next_start_int_enable = I_IO_WDATA[CTL_START_IE]; // RULE19
         next_ovf_int_enable = I_IO_WDATA[CTL_OVF_IE]; // RULE19
         next_wire_select = I_IO_WDATA[CTL_WIRE_HI:CTL_WIRE_LO]; // RULE19
         next_clock_source_select = I_IO_WDATA[CTL_CS_HI:CTL_CS_LO]; // RULE19
         next_ext_soft_sel = eff_soft_sel; // RULE18
      end
      case (eff_cs)
         CS_SOFT: begin
            shift_clk = soft_stb; // RULE23
            cnt_clk = soft_stb; // RULE23
         end
         CS_TIMER: begin
            shift_clk = I_TIMER_MATCH; // RULE5
            cnt_clk = I_TIMER_MATCH; // RULE17
         end
         default: begin
            // bit 0 of the source picks the sampling edge
            shift_clk = eff_cs[0] ? pin_fall[1] : pin_rise[1]; // RULE5 RULE9
            cnt_clk = eff_soft_sel ? tog_stb : scl_edge; // RULE1 RULE17 RULE18 RULE9
         end
      endcase
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         start_int_enable <= CONTROL_RESET[CTL_START_IE];
         ovf_int_enable <= CONTROL_RESET[CTL_OVF_IE];
         wire_select <= CONTROL_RESET[CTL_WIRE_HI:CTL_WIRE_LO];
         clock_source_select <= CONTROL_RESET[CTL_CS_HI:CTL_CS_LO];
         ext_soft_sel <= CONTROL_RESET[CTL_SOFT_CLK];
      end else begin
         start_int_enable <= next_start_int_enable;
         ovf_int_enable <= next_ovf_int_enable;
         wire_select <= next_wire_select;
         clock_source_select <= next_clock_source_select;
         ext_soft_sel <= next_ext_soft_sel;
      end
   end

   // counter, shifter, flags, latch and clock hold
   always_comb begin
      ovf_evt = cnt_clk & ~st_wr & (counter_value == CNT_MAX); // RULE3 RULE12
      next_counter_value = counter_value;
      if (st_wr) begin
         next_counter_value = I_IO_WDATA[ST_CNT_HI:0]; // RULE16 RULE24
      end else if (cnt_clk) begin
         next_counter_value = counter_value + 4'h1; // RULE17
      end
      next_shift_data_register = shift_data_register;
      if (dat_wr) begin
         next_shift_data_register = I_IO_WDATA; // RULE4
      end else if (shift_clk) begin
         next_shift_data_register = {shift_data_register[6:0], sda_level}; // RULE5
      end
      next_receive_buffer_register = ovf_evt ? next_shift_data_register : receive_buffer_register;
      // hardware set wins over a clear in the same cycle
      next_start_cond_flag = (two_wire & start_det) // RULE10
         | (~two_wire & clock_source_select[1] & ~ext_soft_sel & scl_edge) // RULE10
         | (start_cond_flag & ~(st_wr & I_IO_WDATA[ST_START])); // RULE11
      next_counter_ovf_flag = ovf_evt // RULE12
         | (counter_ovf_flag & ~(st_wr & I_IO_WDATA[ST_OVF]) & ~buf_rd); // RULE13
      next_stop_cond_flag = (two_wire & stop_det) // RULE14
         | (stop_cond_flag & ~(st_wr & I_IO_WDATA[ST_STOP])); // RULE14
      // open in the half before the sampling edge, or always when internal
      transparent = ~clock_source_select[1] | (clock_source_select[0] ? scl_level : ~scl_level); // RULE7
      next_out_latch = transparent ? next_shift_data_register[7] : out_latch; // RULE6 RULE8
      next_ovf_pulse = ovf_evt; // RULE2
      next_toggle_pulse = tog_stb;
      next_hold_state = hold_state;
      case (hold_state)
         HOLD_IDLE: begin
            if (two_wire & start_det) begin
               next_hold_state = HOLD_WAIT_FALL;
            end
         end
         HOLD_WAIT_FALL: begin
            if (!next_start_cond_flag) begin
               next_hold_state = HOLD_IDLE; // RULE11
            end else if (pin_fall[1]) begin
               next_hold_state = HOLD_LOW;
            end
         end
         HOLD_LOW: begin
            if (!next_start_cond_flag || !two_wire) begin
               next_hold_state = HOLD_IDLE; // RULE11
            end
         end
         default: begin
            next_hold_state = HOLD_IDLE;
         end
      endcase
      next_rdata = rdata;
      if (I_IO_RE) begin
         case (I_IO_ADDR)
            ADDR_CONTROL: next_rdata = {start_int_enable, ovf_int_enable, wire_select,
               clock_source_select, 2'h0}; // RULE19
            ADDR_STATUS: next_rdata = {start_cond_flag, counter_ovf_flag, stop_cond_flag,
               collision, counter_value}; // RULE20 RULE16
            ADDR_DATA: next_rdata = shift_data_register; // RULE4
            ADDR_BUFFER: next_rdata = receive_buffer_register;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         start_cond_flag <= STATUS_RESET[ST_START];
         counter_ovf_flag <= STATUS_RESET[ST_OVF];
         stop_cond_flag <= STATUS_RESET[ST_STOP];
         counter_value <= STATUS_RESET[ST_CNT_HI:0];
         shift_data_register <= DATA_RESET;
         receive_buffer_register <= DATA_RESET;
         out_latch <= DATA_RESET[7];
         ovf_pulse <= 1'b0;
         toggle_pulse <= 1'b0;
         rdata <= 8'h00;
         hold_state <= HOLD_IDLE;
      end else begin
         start_cond_flag <= next_start_cond_flag;
         counter_ovf_flag <= next_counter_ovf_flag;
         stop_cond_flag <= next_stop_cond_flag;
         counter_value <= next_counter_value;
         shift_data_register <= next_shift_data_register;
         receive_buffer_register <= next_receive_buffer_register;
         out_latch <= next_out_latch;
         ovf_pulse <= next_ovf_pulse;
         toggle_pulse <= next_toggle_pulse;
         rdata <= next_rdata;
         hold_state <= next_hold_state;
      end
   end

   // only meaningful in two-wire mode, but always visible
   assign collision = shift_data_register[7] ^ sda_level; // RULE15
   assign scl_hold = (hold_state == HOLD_LOW)
      | ((wire_select == WIRE_TWO_HOLD) & counter_ovf_flag); // RULE22 RULE13

   assign O_IO_RDATA = rdata;
   // levels follow the flags, so a flag pending at enable fires at once
   assign O_START_IRQ = start_cond_flag & start_int_enable & I_GLOBAL_INT_EN; // RULE11 RULE21
   assign O_OVF_IRQ = counter_ovf_flag & ovf_int_enable & I_GLOBAL_INT_EN; // RULE12 RULE21
   assign O_WAKE_ANY = start_cond_flag & start_int_enable; // RULE11
   assign O_WAKE_IDLE = counter_ovf_flag & ovf_int_enable; // RULE12
   assign O_COUNTER_OVF = ovf_pulse; // RULE2
   assign O_CLOCK_TOGGLE = toggle_pulse;
   assign O_DATA_OUT = out_latch; // RULE6
   assign O_DATA_OUT_EN = (wire_select == WIRE_THREE); // RULE22
   // open-drain lines only ever pull low
   assign O_SDA_OUT = 1'b0;
   assign O_SDA_OE_N = ~(two_wire & ~out_latch); // RULE6 RULE22
   assign O_SCL_OUT = 1'b0;
   assign O_SCL_OE_N = ~(two_wire & scl_hold); // RULE22
endmodule : usi_core

// ===== logic/usi_pin_sync.sv
`timescale 1ns/1ps
module usi_pin_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // raw pins
   input wire logic [WIDTH-1:0] i_pins,
   // synchronised levels and edges
   output logic [WIDTH-1:0] o_level,
   output logic [WIDTH-1:0] o_rise,
   output logic [WIDTH-1:0] o_fall
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] level;
   logic [WIDTH-1:0] prev;

   // first stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta <= '0;
         level <= '0;
         prev <= '0;
      end else begin
         meta <= i_pins;
         level <= meta;
         prev <= level;
      end
   end

   assign o_level = level;
   assign o_rise = level & ~prev;
   assign o_fall = ~level & prev;
endmodule : usi_pin_sync

// ===== shared/usi_pkg.sv
package usi_pkg;
   // register addresses on the i/o port
   localparam logic [5:0] ADDR_CONTROL = 6'h0d;
   localparam logic [5:0] ADDR_STATUS = 6'h0e;
   localparam logic [5:0] ADDR_DATA = 6'h0f;
   localparam logic [5:0] ADDR_BUFFER = 6'h10;
   // control field positions
   localparam int CTL_START_IE = 7;
   localparam int CTL_OVF_IE = 6;
   localparam int CTL_WIRE_HI = 5;
   localparam int CTL_WIRE_LO = 4;
   localparam int CTL_CS_HI = 3;
   localparam int CTL_CS_LO = 2;
   localparam int CTL_SOFT_CLK = 1;
   localparam int CTL_TOGGLE = 0;
   // status field positions
   localparam int ST_START = 7;
   localparam int ST_OVF = 6;
   localparam int ST_STOP = 5;
   localparam int ST_COLL = 4;
   localparam int ST_CNT_HI = 3;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // wire modes and clock sources
   localparam logic [1:0] WIRE_OFF = 2'h0;
   localparam logic [1:0] WIRE_THREE = 2'h1;
   localparam logic [1:0] WIRE_TWO = 2'h2;
   localparam logic [1:0] WIRE_TWO_HOLD = 2'h3;
   localparam logic [1:0] CS_SOFT = 2'h0;
   localparam logic [1:0] CS_TIMER = 2'h1;
   localparam logic [3:0] CNT_MAX = 4'hf;
   localparam int SYNC_STAGES = 2;
   typedef enum logic [1:0] {HOLD_IDLE, HOLD_WAIT_FALL, HOLD_LOW} hold_state_t;
endpackage : usi_pkg

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import usi_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdata = 8'h00;
   logic we = 1'b0;
   logic re = 1'b0;
   logic gie = 1'b0;
   logic match = 1'b0;
   logic [7:0] rdata;
   logic s_irq, o_irq, w_any, w_idle, c_ovf, tgl;
   logic dout, dout_en, sda_o, sda_oe_n, scl_o, scl_oe_n, p_clk, p_data, sda, scl;
   int n_fail = 0;
   int check_count = 0;
   int ovf_seen = 0;
   int tgl_seen = 0;
   // pull-ups: any party pulling low wins
   assign sda = p_data & sda_oe_n;
   assign scl = p_clk & scl_oe_n;
   usi_core usi_core_inst (
      .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_IO_ADDR(addr), .I_IO_WDATA(wdata),
      .I_IO_WE(we), .I_IO_RE(re), .O_IO_RDATA(rdata), .I_GLOBAL_INT_EN(gie),
      .I_TIMER_MATCH(match), .O_START_IRQ(s_irq), .O_OVF_IRQ(o_irq), .O_WAKE_ANY(w_any),
      .O_WAKE_IDLE(w_idle), .O_COUNTER_OVF(c_ovf), .O_CLOCK_TOGGLE(tgl),
      .I_SERIAL_IN_PIN(sda), .I_SERIAL_CLOCK_PIN(scl), .O_DATA_OUT(dout),
      .O_DATA_OUT_EN(dout_en), .O_SDA_OUT(sda_o), .O_SDA_OE_N(sda_oe_n),
      .O_SCL_OUT(scl_o), .O_SCL_OE_N(scl_oe_n)
   );
   usi_serial_partner usi_serial_partner_inst (.o_clk(p_clk), .o_data(p_data));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      if (c_ovf === 1'b1) ovf_seen++;
      if (tgl === 1'b1) tgl_seen++;
   end
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask : cmp
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cycles
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic m = 1'b0);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      we = 1'b1;
      match = m;
      @(posedge clk);
      #1;
      we = 1'b0;
      match = 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      #1;
      addr = a;
      re = 1'b1;
      @(posedge clk);
      #1;
      re = 1'b0;
      cmp(what, exp, rdata);
   endtask : rd
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   initial begin
      #100us;
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      rd(ADDR_CONTROL, CONTROL_RESET, "control");
      rd(ADDR_STATUS, STATUS_RESET, "status");
      wr(6'h20, 8'hff);
      rd(6'h20, 8'h00, "unmapped");
      wr(ADDR_CONTROL, 8'hf0);
      rd(ADDR_CONTROL, 8'hf0, "control rw");
      // two-wire with a zero msb pulls data low, clock stays released
      cmp("open drain", 8'h01, {4'h0, sda_o, scl_o, sda_oe_n, scl_oe_n});
      // software strobes, latch always open
      wr(ADDR_CONTROL, 8'h10);
      wr(ADDR_DATA, 8'hc1);
      cycles(2);
      cmp("data out", 8'h03, {6'h00, dout_en, dout});
      wr(ADDR_STATUS, 8'h4e);
      wr(ADDR_CONTROL, 8'h12);
      wr(ADDR_CONTROL, 8'h12);
      rd(ADDR_DATA, 8'h04, "soft shift");
      rd(ADDR_STATUS, 8'h40, "soft wrap");
      gie = 1'b1;
      cmp("masked ovf", 8'h00, {6'h00, o_irq, w_idle});
      wr(ADDR_CONTROL, 8'h50);
      cycles(1);
      cmp("pending ovf", 8'h03, {6'h00, o_irq, w_idle});
      rd(ADDR_BUFFER, 8'h04, "buffer");
      rd(ADDR_STATUS, 8'h00, "buffer clear");
      // companion timer as clock
      wr(ADDR_CONTROL, 8'h14);
      wr(ADDR_DATA, 8'h5a, 1'b1);
      rd(ADDR_DATA, 8'h5a, "write vs shift");
      wr(ADDR_STATUS, 8'h05, 1'b1);
      // the match beside the status write still shifts 0x5a to 0xb4
      rd(ADDR_STATUS, 8'h15, "write vs count");
      wr(6'h20, 8'h00, 1'b1);
      rd(ADDR_DATA, 8'h68, "timer shift");
      rd(ADDR_STATUS, 8'h06, "timer count");
      // external clock, wires off, counter preset to max
      wr(ADDR_CONTROL, 8'h08);
      wr(ADDR_STATUS, 8'hef);
      usi_serial_partner_inst.send_byte(8'hc3);
      cycles(6);
      rd(ADDR_DATA, 8'hc3, "ext shift");
      rd(ADDR_STATUS, 8'hdf, "ext count");
      wr(ADDR_CONTROL, 8'h88);
      cycles(1);
      cmp("pending start", 8'h03, {6'h00, s_irq, w_any});
      wr(ADDR_STATUS, 8'h80);
      cycles(1);
      cmp("start clear", 8'h00, {6'h00, s_irq, w_any});
      // two-wire start, hold and stop
      wr(ADDR_CONTROL, 8'hac);
      usi_serial_partner_inst.bus_idle();
      wr(ADDR_DATA, 8'hff);
      wr(ADDR_STATUS, 8'he0);
      usi_serial_partner_inst.start_cond();
      cycles(6);
      cmp("start hold", 8'h01, {6'h00, scl_oe_n, s_irq});
      wr(ADDR_STATUS, 8'h80);
      cycles(4);
      cmp("hold release", 8'h02, {6'h00, scl_oe_n, s_irq});
      usi_serial_partner_inst.stop_cond();
      cycles(6);
      rd(ADDR_STATUS, 8'h21, "stop flag");
      cmp("stop irq", 8'h00, {7'h00, s_irq});
      // overflow hold, counter clocked by the toggle strobe
      wr(ADDR_CONTROL, 8'h3e);
      wr(ADDR_STATUS, 8'hef);
      wr(ADDR_CONTROL, 8'h3f);
      cycles(2);
      cmp("ovf hold", 8'h00, {7'h00, scl_oe_n});
      rd(ADDR_STATUS, 8'h40, "toggle count");
      wr(ADDR_STATUS, 8'h40);
      cycles(2);
      cmp("ovf release", 8'h01, {7'h00, scl_oe_n});
      cmp("pulses", 8'h31, {ovf_seen[3:0], tgl_seen[3:0]});
      wrap_up();
   end
endmodule : tb_top

// ===== sim/usi_core_monitor.sv
`timescale 1ns/1ps
module usi_core_monitor
   import usi_pkg::*;
(
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   // register port
   input wire logic [5:0] I_IO_ADDR,
   input wire logic [7:0] I_IO_WDATA,
   input wire logic I_IO_WE,
   input wire logic I_IO_RE,
   input wire logic [7:0] O_IO_RDATA,
   // processor side
   input wire logic O_START_IRQ,
   input wire logic O_OVF_IRQ,
   input wire logic O_WAKE_ANY,
   input wire logic O_WAKE_IDLE,
   input wire logic O_COUNTER_OVF,
   input wire logic O_CLOCK_TOGGLE,
   // serial pins
   input wire logic O_DATA_OUT_EN,
   input wire logic O_SDA_OE_N,
   input wire logic O_SCL_OE_N
);
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_SYS_RST);
   logic rd_unmapped;
   assign rd_unmapped = I_IO_RE && (I_IO_ADDR < ADDR_CONTROL || I_IO_ADDR > ADDR_BUFFER);

   a_start_irq_wake: assert property (O_START_IRQ |-> O_WAKE_ANY)
      else $error("start irq without wake");
   a_ovf_irq_wake: assert property (O_OVF_IRQ |-> O_WAKE_IDLE)
      else $error("overflow irq without wake");
   // without a status write, sixteen counts lie between two wraps, so pulses are never close
   a_ovf_pulse_apart: assert property (O_COUNTER_OVF |=> !O_COUNTER_OVF [*8])
      else $error("overflow pulses too close");
   a_toggle_pulse: assert property (O_CLOCK_TOGGLE == (!$past(I_SYS_RST) &&
      $past(I_IO_WE && I_IO_ADDR == ADDR_CONTROL && I_IO_WDATA[CTL_TOGGLE])))
      else $error("toggle pulse mismatch");
   a_rdata_holds: assert property (!$past(I_IO_RE) && !$past(I_SYS_RST) |-> $stable(O_IO_RDATA))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (rd_unmapped |=> O_IO_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_strobes_read_zero: assert property (I_IO_RE && I_IO_ADDR == ADDR_CONTROL
      |=> O_IO_RDATA[CTL_SOFT_CLK:CTL_TOGGLE] == 2'h0)
      else $error("control strobe bits read back");
   a_wire_exclusive: assert property (O_DATA_OUT_EN [*2] |-> O_SDA_OE_N)
      else $error("data pulled in three-wire mode");
   a_reset_quiet: assert property ($fell(I_SYS_RST) |-> !O_START_IRQ && !O_OVF_IRQ &&
      O_SDA_OE_N && O_SCL_OE_N && !O_DATA_OUT_EN && O_IO_RDATA == 8'h00)
      else $error("outputs not idle after reset");
endmodule : usi_core_monitor

bind usi_core usi_core_monitor usi_core_monitor_inst (
   .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_IO_ADDR(I_IO_ADDR),
   .I_IO_WDATA(I_IO_WDATA), .I_IO_WE(I_IO_WE), .I_IO_RE(I_IO_RE), .O_IO_RDATA(O_IO_RDATA),
   .O_START_IRQ(O_START_IRQ), .O_OVF_IRQ(O_OVF_IRQ), .O_WAKE_ANY(O_WAKE_ANY),
   .O_WAKE_IDLE(O_WAKE_IDLE), .O_COUNTER_OVF(O_COUNTER_OVF), .O_CLOCK_TOGGLE(O_CLOCK_TOGGLE),
   .O_DATA_OUT_EN(O_DATA_OUT_EN), .O_SDA_OE_N(O_SDA_OE_N), .O_SCL_OE_N(O_SCL_OE_N)
);

// ===== sim/usi_serial_partner.sv
`timescale 1ns/1ps
module usi_serial_partner (
   // lines toward the device
   output logic o_clk,
   output logic o_data
);
   // half of the 80 ns link period
   localparam time HALF = 40ns;
   initial begin
      o_clk = 1'b0;
      o_data = 1'b0;
   end
   // msb first, clock stands still low between frames
   task automatic send_byte(input logic [7:0] b);
      #3;
      for (int i = 7; i >= 0; i--) begin
         o_data = b[i];
         #HALF;
         o_clk = 1'b1;
         #HALF;
         o_clk = 1'b0;
      end
      // released line shows the inverse so a stale bit is never mistaken
      o_data = ~b[0];
   endtask : send_byte
   // data first so the pair never looks like a stop
   task automatic bus_idle;
      o_data = 1'b1;
      #HALF;
      o_clk = 1'b1;
      #HALF;
   endtask : bus_idle
   task automatic start_cond;
      o_data = 1'b0;
      #HALF;
      o_clk = 1'b0;
      #HALF;
   endtask : start_cond
   task automatic stop_cond;
      #HALF;
      o_clk = 1'b1;
      #HALF;
      o_data = 1'b1;
      #HALF;
   endtask : stop_cond
endmodule : usi_serial_partner
